// file: hw/custom_logic_unit.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Gated D flop: reset clears, gate loads D
// - JK flop: hold, clear, set, toggle
// - Gated D latch follows D while gate high
// - Set/clear latch: hold, clear, set
// - Select zero disables; codes above four reserved
// - Clocked logic uses peripheral clock by default
// - Clock select uses input 2 as clock
// - Pair sequencer uses even table's clock
// - Input 2 indexes as low when clocking
// - Table outputs are events; events feed inputs
// - Standby run requests clock in standby while unit enabled and clocked logic used
// - Standby without run forces outputs of peripheral-clocked tables using clocked logic low
// - Idle keeps combinational decoder running
// - Input 2 clock works in every sleep
// - Global bit 0 enables unit; resets zero
// - Control A bit 7 enables edge pulse
// - Output is function bit at index in2:in0
// - Even table disable clears sequencer
// - Filter codes: none, synchronizer, filter, reserved
module custom_logic_unit
  import custom_logic_unit_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [5:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [5:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [3:0] i_event_table_input,
  input wire logic [5:0] i_table_pin_input,
  input wire logic [5:0] i_periph_source,
  input wire logic i_standby_sleep,
  input wire logic i_idle_sleep,
  output logic o_peripheral_clock_request,
  output logic [1:0] o_table_output_event,
  output logic [1:0] o_table_pin_out,
  output logic [1:0] o_pin_drive_enable
);

  logic [7:0] global_reg;
  logic [3:0] seq_select_reg;
  logic [7:0] ctrl_a_reg [2];
  logic [7:0] sel_low_reg [2];
  logic [7:0] sel_high_reg [2];
  logic [7:0] truth_reg [2];
  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [3:0] aw_idx_reg;
  logic [7:0] w_data_reg;
  logic w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic [1:0] sync_a_reg, sync_b_reg, maj_reg, filt_out_reg, edge_prev_reg;
  logic [1:0] in2_prev_reg;
  logic seq_out_reg, seq_clear_reg;
  logic [1:0] event_reg, pin_reg;

  function automatic logic mapped(input logic [3:0] idx);
    mapped = (idx <= IDX_PAIR_SEQUENCER_SELECT) ||
             ((idx >= IDX_TABLE0_CONTROL_A) && (idx <= IDX_UNIT_STATUS));
  endfunction

  function automatic logic pick(input logic [3:0] code, input logic fb, input logic lnk,
                                input logic ev_a, input logic ev_b, input logic pin);
    logic r;
    r = 1'b0;
    case (code)
      SRC_MASK: r = 1'b0;
      SRC_FEEDBACK: r = fb;
      SRC_LINK: r = lnk;
      SRC_EVENT_A: r = ev_a;
      SRC_EVENT_B: r = ev_b;
      SRC_PIN: r = pin;
      default: begin
        if (code >= SRC_PERIPH_FIRST && code <= SRC_PERIPH_LAST) begin
          r = i_periph_source[3'(code - SRC_PERIPH_FIRST)];
        end
      end
    endcase
    pick = r;
  endfunction

  // Bus handshake
  logic write_fire;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  assign o_s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign o_s_axi_wready = !w_held_reg && !bvalid_reg;
  assign o_s_axi_arready = !rvalid_reg;
  assign write_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_idx = aw_idx_reg;
  assign rd_idx = i_s_axi_araddr[5:2];
  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp = bresp_reg;
  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rresp = rresp_reg;
  assign o_s_axi_rdata = rdata_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_idx_reg <= 4'h0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg <= i_s_axi_awaddr[5:2];
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= i_s_axi_wdata[7:0];
        w_strb_reg <= i_s_axi_wstrb[0];
      end
      if (write_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (mapped(wr_idx) && wr_idx != IDX_UNIT_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && i_s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Register writes
  logic do_write;
  assign do_write = write_fire && w_strb_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      global_reg <= RST_UNIT_GLOBAL_CONTROL;
      seq_select_reg <= RST_SEQUENCER_SELECT;
    end else if (do_write) begin
      if (wr_idx == IDX_UNIT_GLOBAL_CONTROL) begin
        global_reg <= w_data_reg & 8'h41;
      end
      if (wr_idx == IDX_PAIR_SEQUENCER_SELECT) begin
        seq_select_reg <= w_data_reg[3:0];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      for (int t = 0; t < 2; t++) begin
        ctrl_a_reg[t] <= RST_TABLE_CONTROL_A;
        sel_low_reg[t] <= RST_TABLE_INPUT_SELECT;
        sel_high_reg[t] <= RST_TABLE_INPUT_SELECT;
        truth_reg[t] <= RST_TABLE_FUNCTION_BITS;
      end
    end else if (do_write) begin
      for (int t = 0; t < 2; t++) begin
        if (wr_idx == 4'(IDX_TABLE0_CONTROL_A + t * TABLE_STRIDE)) begin
          ctrl_a_reg[t] <= w_data_reg & 8'hf9;
        end
        if (wr_idx == 4'(IDX_TABLE0_INPUT_SELECT_LOW + t * TABLE_STRIDE)) begin
          sel_low_reg[t] <= w_data_reg;
        end
        if (wr_idx == 4'(IDX_TABLE0_INPUT_SELECT_HIGH + t * TABLE_STRIDE)) begin
          sel_high_reg[t] <= {4'h0, w_data_reg[3:0]};
        end
        if (wr_idx == 4'(IDX_TABLE0_FUNCTION_BITS + t * TABLE_STRIDE)) begin
          truth_reg[t] <= w_data_reg;
        end
      end
    end
  end

  // Register reads
  logic [7:0] rd_value;
  always_comb begin
    rd_value = 8'h00;
    case (rd_idx)
      IDX_UNIT_GLOBAL_CONTROL: rd_value = global_reg;
      IDX_PAIR_SEQUENCER_SELECT: rd_value = {4'h0, seq_select_reg};
      IDX_TABLE0_CONTROL_A: rd_value = ctrl_a_reg[0];
      IDX_TABLE0_INPUT_SELECT_LOW: rd_value = sel_low_reg[0];
      IDX_TABLE0_INPUT_SELECT_HIGH: rd_value = sel_high_reg[0];
      IDX_TABLE0_FUNCTION_BITS: rd_value = truth_reg[0];
      IDX_TABLE1_CONTROL_A: rd_value = ctrl_a_reg[1];
      IDX_TABLE1_INPUT_SELECT_LOW: rd_value = sel_low_reg[1];
      IDX_TABLE1_INPUT_SELECT_HIGH: rd_value = sel_high_reg[1];
      IDX_TABLE1_FUNCTION_BITS: rd_value = truth_reg[1];
      IDX_UNIT_STATUS: rd_value = {5'h00, seq_out_reg, event_reg};
      default: rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_value};
      rresp_reg <= mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Table datapath
  logic unit_en, periph_clk_run;
  logic [1:0] tbl_en, clk_sel, edge_en, tick, uses_clocked, comb_out, stage_out;
  logic [1:0] raw_in2;
  logic [2:0] idx [2];
  logic [1:0] filt_sel [2];

  assign unit_en = global_reg[BIT_UNIT_ENABLE];
  assign periph_clk_run = !(i_standby_sleep && !global_reg[BIT_STANDBY_RUN]);
  assign o_peripheral_clock_request = unit_en && i_standby_sleep &&
                                      global_reg[BIT_STANDBY_RUN] && (|uses_clocked);

  always_comb begin
    for (int t = 0; t < 2; t++) begin
      tbl_en[t] = unit_en && ctrl_a_reg[t][BIT_TABLE_ENABLE];
      clk_sel[t] = ctrl_a_reg[t][BIT_TABLE_CLOCK_SELECT];
      edge_en[t] = ctrl_a_reg[t][BIT_EDGE_PULSE_ENABLE];
      filt_sel[t] = ctrl_a_reg[t][BIT_FILTER_LSB +: 2];
      idx[t][0] = pick(sel_low_reg[t][3:0], seq_out_reg, comb_out[1 - t],
                       i_event_table_input[t], i_event_table_input[t + 2], i_table_pin_input[3 * t]);
      idx[t][1] = pick(sel_low_reg[t][7:4], seq_out_reg, comb_out[1 - t],
                       i_event_table_input[t], i_event_table_input[t + 2],
                       i_table_pin_input[3 * t + 1]);
      raw_in2[t] = pick(sel_high_reg[t][3:0], seq_out_reg, comb_out[1 - t],
                        i_event_table_input[0], i_event_table_input[1],
                        i_table_pin_input[3 * t + 2]);
      idx[t][2] = clk_sel[t] ? 1'b0 : raw_in2[t];
      comb_out[t] = truth_reg[t][idx[t]] && tbl_en[t];
      // Input 2 rising edge, or the running peripheral clock
      tick[t] = clk_sel[t] ? (raw_in2[t] && !in2_prev_reg[t]) : periph_clk_run;
      uses_clocked[t] = (filt_sel[t] != FILT_NONE) || edge_en[t] ||
                        (seq_select_reg != SEQ_DISABLE);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      in2_prev_reg <= 2'b00;
    end else begin
      for (int t = 0; t < 2; t++) begin
        in2_prev_reg[t] <= raw_in2[t];
      end
    end
  end

  // Filter and edge detector
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sync_a_reg <= 2'b00;
      sync_b_reg <= 2'b00;
      maj_reg <= 2'b00;
      filt_out_reg <= 2'b00;
      edge_prev_reg <= 2'b00;
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (!tbl_en[t]) begin
          sync_a_reg[t] <= 1'b0;
          sync_b_reg[t] <= 1'b0;
          maj_reg[t] <= 1'b0;
          filt_out_reg[t] <= 1'b0;
          edge_prev_reg[t] <= 1'b0;
        end else if (tick[t]) begin
          sync_a_reg[t] <= comb_out[t];
          sync_b_reg[t] <= sync_a_reg[t];
          maj_reg[t] <= sync_b_reg[t];
          filt_out_reg[t] <= (sync_a_reg[t] & sync_b_reg[t]) | (sync_b_reg[t] & maj_reg[t]) |
                             (sync_a_reg[t] & maj_reg[t]);
          edge_prev_reg[t] <= stage_out[t];
        end
      end
    end
  end

  logic [1:0] filtered, pulsed;
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      case (filt_sel[t])
        FILT_NONE: filtered[t] = comb_out[t];
        FILT_TWO_STAGE_SYNCHRONIZER: filtered[t] = sync_b_reg[t];
        FILT_MAJORITY: filtered[t] = filt_out_reg[t];
        default: filtered[t] = 1'b0;
      endcase
      stage_out[t] = filtered[t];
      pulsed[t] = edge_en[t] ? (filtered[t] && !edge_prev_reg[t]) : filtered[t];
    end
  end

  // Pair sequencer, clocked by even table
  logic seq_next, seq_active, seq_d, seq_g;
  assign seq_d = pulsed[0];
  assign seq_g = pulsed[1];
  assign seq_active = (seq_select_reg >= SEQ_GATED_D_FLIPFLOP) &&
                      (seq_select_reg <= SEQ_SET_CLEAR_STORE);

  always_comb begin
    seq_next = seq_out_reg;
    case (seq_select_reg)
      SEQ_GATED_D_FLIPFLOP: begin
        if (seq_g) begin
          seq_next = seq_d;
        end
      end
      SEQ_SET_CLEAR_TOGGLE_FLIPFLOP: begin
        case ({seq_d, seq_g})
          2'b01: seq_next = 1'b0;
          2'b10: seq_next = 1'b1;
          2'b11: seq_next = !seq_out_reg;
          default: seq_next = seq_out_reg;
        endcase
      end
      SEQ_GATED_D_LATCH: begin
        if (seq_g) begin
          seq_next = seq_d;
        end
      end
      SEQ_SET_CLEAR_STORE: begin
        case ({seq_d, seq_g})
          2'b01: seq_next = 1'b0;
          2'b10: seq_next = 1'b1;
          2'b11: seq_next = 1'b0;
          default: seq_next = seq_out_reg;
        endcase
      end
      default: seq_next = 1'b0;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      seq_clear_reg <= 1'b1;
      seq_out_reg <= 1'b0;
    end else begin
      seq_clear_reg <= !tbl_en[0];
      if (!tbl_en[0] || seq_clear_reg) begin
        seq_out_reg <= 1'b0;
      end else if (!seq_active) begin
        seq_out_reg <= 1'b0;
      end else if (tick[0]) begin
        seq_out_reg <= seq_next;
      end
    end
  end

  // Output events and pins
  logic [1:0] final_out;
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      final_out[t] = seq_active ? seq_out_reg : pulsed[t];
      if (i_standby_sleep && !global_reg[BIT_STANDBY_RUN] && !clk_sel[t] && uses_clocked[t]) begin
        final_out[t] = 1'b0;
      end
      if (!tbl_en[t]) begin
        final_out[t] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      event_reg <= 2'b00;
      pin_reg <= 2'b00;
    end else begin
      event_reg <= final_out;
      for (int t = 0; t < 2; t++) begin
        pin_reg[t] <= ctrl_a_reg[t][BIT_PIN_DRIVE_ENABLE] && tbl_en[t];
      end
    end
  end

  assign o_table_output_event = event_reg;
  assign o_table_pin_out = event_reg;
  assign o_pin_drive_enable = pin_reg;

  // left to software: no clock-change guard here
  logic unused_idle;
  assign unused_idle = i_idle_sleep;

endmodule

`default_nettype wire

// file: hw/custom_logic_unit_pkg.sv
package custom_logic_unit_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] IDX_UNIT_GLOBAL_CONTROL = 4'h0;
  localparam logic [3:0] IDX_PAIR_SEQUENCER_SELECT = 4'h1;
  localparam logic [3:0] IDX_TABLE0_CONTROL_A = 4'h5;
  localparam logic [3:0] IDX_TABLE0_INPUT_SELECT_LOW = 4'h6;
  localparam logic [3:0] IDX_TABLE0_INPUT_SELECT_HIGH = 4'h7;
  localparam logic [3:0] IDX_TABLE0_FUNCTION_BITS = 4'h8;
  localparam logic [3:0] IDX_TABLE1_CONTROL_A = 4'h9;
  localparam logic [3:0] IDX_TABLE1_INPUT_SELECT_LOW = 4'ha;
  localparam logic [3:0] IDX_TABLE1_INPUT_SELECT_HIGH = 4'hb;
  localparam logic [3:0] IDX_TABLE1_FUNCTION_BITS = 4'hc;
  localparam logic [3:0] IDX_UNIT_STATUS = 4'hd;
  localparam int TABLE_STRIDE = 4;

  // Field positions
  localparam int BIT_UNIT_ENABLE = 0;
  localparam int BIT_STANDBY_RUN = 6;
  localparam int BIT_TABLE_ENABLE = 0;
  localparam int BIT_PIN_DRIVE_ENABLE = 3;
  localparam int BIT_FILTER_LSB = 4;
  localparam int BIT_TABLE_CLOCK_SELECT = 6;
  localparam int BIT_EDGE_PULSE_ENABLE = 7;

  // Reset values
  localparam logic [7:0] RST_UNIT_GLOBAL_CONTROL = 8'h00;
  localparam logic [3:0] RST_SEQUENCER_SELECT = 4'h0;
  localparam logic [7:0] RST_TABLE_CONTROL_A = 8'h00;
  localparam logic [7:0] RST_TABLE_INPUT_SELECT = 8'h00;
  localparam logic [7:0] RST_TABLE_FUNCTION_BITS = 8'h00;

  // Sequencer function select codes
  localparam logic [3:0] SEQ_DISABLE = 4'h0;
  localparam logic [3:0] SEQ_GATED_D_FLIPFLOP = 4'h1;
  localparam logic [3:0] SEQ_SET_CLEAR_TOGGLE_FLIPFLOP = 4'h2;
  localparam logic [3:0] SEQ_GATED_D_LATCH = 4'h3;
  localparam logic [3:0] SEQ_SET_CLEAR_STORE = 4'h4;

  // Output filter select codes
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_TWO_STAGE_SYNCHRONIZER = 2'h1;
  localparam logic [1:0] FILT_MAJORITY = 2'h2;

  // Table input source codes
  localparam logic [3:0] SRC_MASK = 4'h0;
  localparam logic [3:0] SRC_FEEDBACK = 4'h1;
  localparam logic [3:0] SRC_LINK = 4'h2;
  localparam logic [3:0] SRC_EVENT_A = 4'h3;
  localparam logic [3:0] SRC_EVENT_B = 4'h4;
  localparam logic [3:0] SRC_PIN = 4'h5;
  localparam logic [3:0] SRC_PERIPH_FIRST = 4'h6;
  localparam logic [3:0] SRC_PERIPH_LAST = 4'hb;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// file: tb/custom_logic_unit_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module custom_logic_unit_asserts
  import custom_logic_unit_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [5:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic i_standby_sleep,
  input wire logic o_peripheral_clock_request,
  input wire logic [1:0] o_table_output_event,
  input wire logic [1:0] o_table_pin_out,
  input wire logic [1:0] o_pin_drive_enable
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  AST_WRITE_ANSWER: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
    && o_s_axi_wready |-> ##[1:2] o_s_axi_bvalid) else $error("write answer missing");
  AST_WRITE_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("write answer dropped");
  AST_READ_ANSWER: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read answer late");
  AST_READ_HOLD: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
    o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read answer changed");
  AST_BUSY_REFUSE: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken while answer pending");
  AST_READ_REFUSE: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken while answer pending");
  AST_UPPER_ZERO: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_UNMAPPED_READ: assert property (i_s_axi_arvalid && o_s_axi_arready &&
    i_s_axi_araddr[5:2] > IDX_UNIT_STATUS |=> o_s_axi_rresp == RESP_SLVERR &&
    o_s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  AST_CLOCK_REQUEST: assert property (!i_standby_sleep |-> !o_peripheral_clock_request)
    else $error("clock request outside standby");
  AST_PIN_FOLLOWS: assert property (o_table_pin_out == o_table_output_event)
    else $error("pin output differs from event");
  AST_RESET_OUTPUTS: assert property ($rose(i_rst_n) |-> o_table_output_event == 2'h0 &&
    o_pin_drive_enable == 2'h0) else $error("outputs set after reset");

  cover property (o_s_axi_bvalid && i_s_axi_bready);
  cover property (o_s_axi_rvalid && i_s_axi_rready);
  cover property (o_peripheral_clock_request);
  cover property ($rose(o_table_output_event[0]));
endmodule
bind custom_logic_unit custom_logic_unit_asserts i_custom_logic_unit_asserts (.i_clock,
  .i_rst_n, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready,
  .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
  .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_standby_sleep,
  .o_peripheral_clock_request, .o_table_output_event, .o_table_pin_out, .o_pin_drive_enable);
`default_nettype wire

// file: tb/event_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module event_source_model (
  input wire logic i_clock,
  input wire logic [3:0] i_event_cmd,
  input wire logic [5:0] i_pin_cmd,
  output logic [3:0] o_event = 4'h0,
  output logic [5:0] o_pin = 6'h0,
  output logic [5:0] o_periph = 6'h0
);
  // Peripheral sources never rest
  always @(posedge i_clock) begin
    o_event <= i_event_cmd;
    o_pin <= i_pin_cmd;
    o_periph <= {o_periph[4:0], ~o_periph[5]};
  end
endmodule
`default_nettype wire

// file: tb/tb_custom_logic_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_custom_logic_unit;
  import custom_logic_unit_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [5:0] i_s_axi_awaddr = 6'h0;
  logic [5:0] i_s_axi_araddr = 6'h0;
  logic [31:0] i_s_axi_wdata = 32'h0;
  logic [3:0] i_s_axi_wstrb = 4'h0;
  logic i_s_axi_awvalid = 1'b0;
  logic i_s_axi_wvalid = 1'b0;
  logic i_s_axi_bready = 1'b0;
  logic i_s_axi_arvalid = 1'b0;
  logic i_s_axi_rready = 1'b0;
  logic i_standby_sleep = 1'b0;
  logic i_idle_sleep = 1'b0;
  logic [3:0] ev_cmd = 4'h0;
  logic [5:0] pin_cmd = 6'h0;
  logic [3:0] i_event_table_input;
  logic [5:0] i_table_pin_input;
  logic [5:0] i_periph_source;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  logic [31:0] o_s_axi_rdata;
  logic o_peripheral_clock_request;
  logic [1:0] o_table_output_event, o_table_pin_out, o_pin_drive_enable;
  logic [11:0] cfg [9] = '{12'h000, 12'h603, 12'h700, 12'h8aa, 12'ha03, 12'hb00, 12'hcaa,
    12'h901, 12'h001};
  int err_count = 0;
  int samples_checked = 0;

  always #2.5 i_clock = ~i_clock;

  event_source_model i_event_source_model (.i_clock, .i_event_cmd(ev_cmd), .i_pin_cmd(pin_cmd),
    .o_event(i_event_table_input), .o_pin(i_table_pin_input), .o_periph(i_periph_source));

  custom_logic_unit i_custom_logic_unit (.i_clock, .i_rst_n, .i_s_axi_awaddr, .i_s_axi_awvalid,
    .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
    .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
    .i_event_table_input, .i_table_pin_input, .i_periph_source, .i_standby_sleep,
    .i_idle_sleep, .o_peripheral_clock_request, .o_table_output_event, .o_table_pin_out,
    .o_pin_drive_enable);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic [3:0] s,
    input logic [1:0] r);
    logic da, dw, ha, hw;
    @(posedge i_clock);
    i_s_axi_awaddr <= {idx, 2'b00};
    i_s_axi_wdata <= {24'h0, d};
    i_s_axi_wstrb <= s;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    da = 1'b0;
    dw = 1'b0;
    while (!(da && dw)) begin
      @(negedge i_clock);
      ha = o_s_axi_awready && !da;
      hw = o_s_axi_wready && !dw;
      @(posedge i_clock);
      if (ha) begin
        i_s_axi_awvalid <= 1'b0;
        da = 1'b1;
      end
      if (hw) begin
        i_s_axi_wvalid <= 1'b0;
        dw = 1'b1;
      end
    end
    do @(negedge i_clock); while (o_s_axi_bvalid !== 1'b1);
    chk({30'h0, o_s_axi_bresp}, {30'h0, r});
    @(posedge i_clock);
    i_s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] idx, input logic [7:0] d, input logic [1:0] r);
    @(posedge i_clock);
    i_s_axi_araddr <= {idx, 2'b00};
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do @(negedge i_clock); while (o_s_axi_arready !== 1'b1);
    @(posedge i_clock);
    i_s_axi_arvalid <= 1'b0;
    do @(negedge i_clock); while (o_s_axi_rvalid !== 1'b1);
    chk(o_s_axi_rdata, {24'h0, d});
    chk({30'h0, o_s_axi_rresp}, {30'h0, r});
    @(posedge i_clock);
    i_s_axi_rready <= 1'b0;
  endtask

  function automatic logic [1:0] resp_of(input logic [3:0] i);
    return (i inside {4'h2, 4'h3, 4'h4} || i > IDX_UNIT_STATUS) ? RESP_SLVERR : RESP_OKAY;
  endfunction

  function automatic logic seq_next(input logic [3:0] m, input logic q, a, b);
    case (m)
      SEQ_GATED_D_FLIPFLOP, SEQ_GATED_D_LATCH: return b ? a : q;
      SEQ_SET_CLEAR_TOGGLE_FLIPFLOP: return (a && b) ? !q : (a ? 1'b1 : (b ? 1'b0 : q));
      default: return b ? 1'b0 : (a ? 1'b1 : q);
    endcase
  endfunction

  initial begin
    #200000;
    err_count++;
    close_out();
  end

  initial begin
    logic [7:0] t;
    logic [3:0] m;
    logic q, a, b;
    logic [11:0] seen_bits;
    int k;
    k = $urandom(4);
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    for (k = 0; k < 16; k++) rd(k[3:0], 8'h00, resp_of(k[3:0]));
    wr(IDX_UNIT_GLOBAL_CONTROL, 8'hff, 4'h1, RESP_OKAY);
    rd(IDX_UNIT_GLOBAL_CONTROL, 8'h41, RESP_OKAY);
    wr(IDX_UNIT_GLOBAL_CONTROL, 8'h00, 4'h0, RESP_OKAY);
    rd(IDX_UNIT_GLOBAL_CONTROL, 8'h41, RESP_OKAY);
    wr(IDX_PAIR_SEQUENCER_SELECT, 8'hff, 4'h1, RESP_OKAY);
    rd(IDX_PAIR_SEQUENCER_SELECT, 8'h0f, RESP_OKAY);
    wr(IDX_PAIR_SEQUENCER_SELECT, 8'h00, 4'h1, RESP_OKAY);
    wr(IDX_TABLE0_CONTROL_A, 8'hff, 4'h1, RESP_OKAY);
    rd(IDX_TABLE0_CONTROL_A, 8'hf9, RESP_OKAY);
    wr(IDX_TABLE0_CONTROL_A, 8'h00, 4'h1, RESP_OKAY);
    wr(IDX_UNIT_STATUS, 8'h11, 4'h1, RESP_SLVERR);
    wr(4'he, 8'h11, 4'h1, RESP_SLVERR);
    wr(IDX_UNIT_GLOBAL_CONTROL, 8'h01, 4'h1, RESP_OKAY);
    pin_cmd <= 6'h20;
    wr(IDX_TABLE1_INPUT_SELECT_HIGH, 8'h05, 4'h1, RESP_OKAY);
    wr(IDX_TABLE1_FUNCTION_BITS, 8'hf0, 4'h1, RESP_OKAY);
    wr(IDX_TABLE1_CONTROL_A, 8'h09, 4'h1, RESP_OKAY);
    settle(4);
    chk({o_pin_drive_enable, o_table_output_event[1]}, 3'b101);
    wr(IDX_UNIT_GLOBAL_CONTROL, 8'h00, 4'h1, RESP_OKAY);
    wr(IDX_TABLE1_CONTROL_A, 8'h49, 4'h1, RESP_OKAY);
    wr(IDX_UNIT_GLOBAL_CONTROL, 8'h01, 4'h1, RESP_OKAY);
    settle(4);
    chk(o_table_output_event[1], 1'b0);
    wr(IDX_TABLE0_INPUT_SELECT_LOW, 8'h43, 4'h1, RESP_OKAY);
    wr(IDX_TABLE0_INPUT_SELECT_HIGH, 8'h05, 4'h1, RESP_OKAY);
    wr(IDX_TABLE0_CONTROL_A, 8'h01, 4'h1, RESP_OKAY);
    repeat (24) begin
      t = 8'($urandom);
      wr(IDX_TABLE0_FUNCTION_BITS, t, 4'h1, RESP_OKAY);
      ev_cmd <= 4'($urandom);
      pin_cmd <= 6'($urandom);
      i_idle_sleep <= 1'($urandom);
      settle(4);
      chk(o_table_output_event[0], t[{i_table_pin_input[2], i_event_table_input[2],
        i_event_table_input[0]}]);
    end
    @(posedge i_clock);
    i_idle_sleep <= 1'b0;
    ev_cmd <= 4'h0;
    foreach (cfg[k]) wr(cfg[k][11:8], cfg[k][7:0], 4'h1, RESP_OKAY);
    // Synchronizer, majority filter, then majority with edge pulse on a held event
    for (m = 4'h1; m < 4'h4; m++) begin
      wr(IDX_TABLE0_CONTROL_A, (m == 4'h3) ? 8'ha1 : {2'b00, m[1:0], 4'h1}, 4'h1, RESP_OKAY);
      @(posedge i_clock);
      ev_cmd <= 4'h1;
      for (k = 0; k < 12; k++) begin
        @(negedge i_clock);
        seen_bits[k] = o_table_output_event[0];
      end
      chk(seen_bits, (m == 4'h1) ? 12'hff0 : ((m == 4'h2) ? 12'hfe0 : 12'h020));
      @(posedge i_clock);
      ev_cmd <= 4'h0;
      settle(8);
    end
    for (m = 4'h1; m < 4'h5; m++) begin
      wr(IDX_TABLE0_CONTROL_A, 8'h00, 4'h1, RESP_OKAY);
      wr(IDX_PAIR_SEQUENCER_SELECT, {4'h0, m}, 4'h1, RESP_OKAY);
      wr(IDX_TABLE0_CONTROL_A, 8'h01, 4'h1, RESP_OKAY);
      q = 1'b0;
      for (k = 0; k < 12; k++) begin
        {a, b} = (k < 4) ? 2'(k) : 2'($urandom);
        @(posedge i_clock);
        ev_cmd <= {2'b00, b, a};
        @(posedge i_clock);
        ev_cmd <= 4'h0;
        settle(3);
        q = seq_next(m, q, a, b);
        chk({o_table_output_event, o_table_pin_out}, {4{q}});
      end
    end
    @(posedge i_clock);
    i_standby_sleep <= 1'b1;
    settle(3);
    chk({o_table_output_event, o_peripheral_clock_request}, 3'b000);
    wr(IDX_UNIT_GLOBAL_CONTROL, 8'h41, 4'h1, RESP_OKAY);
    settle(3);
    chk({o_table_output_event, o_peripheral_clock_request}, {q, q, 1'b1});
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    i_standby_sleep <= 1'b0;
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    rd(IDX_UNIT_GLOBAL_CONTROL, 8'h00, RESP_OKAY);
    settle(1);
    chk({o_table_output_event, o_pin_drive_enable}, 4'h0);
    close_out();
  end
endmodule
`default_nettype wire
